// >>> src/srbt_pkg.sv
// Purpose: shared constants of the scannable registered bus transceiver
// Assumes: 32-bit AXI4-Lite data, 4-bit byte address
// Notes:   register offsets are byte addresses, one aligned word each
package srbt_pkg;
    localparam int unsigned BITS       = 3;
    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned STRB_W     = 4;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned FIFO_W     = 2 * BITS;

    // register map
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_TXDATA = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;

    // control fields
    localparam int unsigned CTRL_TX_LOAD   = 0;
    localparam int unsigned CTRL_RX_LOAD   = 1;
    localparam int unsigned CTRL_SCAN      = 2;
    localparam int unsigned CTRL_SYNC_EN   = 3;
    localparam int unsigned CTRL_ASYNC_OFF = 4;
    localparam int unsigned CTRL_PRESET_N  = 5;
    localparam int unsigned CTRL_SERIAL_IN = 6;
    localparam int unsigned CTRL_W         = 7;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h20;

    // transmit data word fields
    localparam int unsigned TX_A_LSB = 0;
    localparam int unsigned TX_B_LSB = 4;

    // status fields
    localparam int unsigned ST_TX_LSB     = 0;
    localparam int unsigned ST_RX_LSB     = 4;
    localparam int unsigned ST_EN_FF      = 8;
    localparam int unsigned ST_DRIVE      = 9;
    localparam int unsigned ST_FIFO_EMPTY = 10;
    localparam int unsigned ST_FIFO_FULL  = 11;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : srbt_pkg

// >>> src/srbt_fifo.sv
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: synchronous active-high reset, DEPTH of at least 2
// Notes:   in_ready drops when full, so the source really stalls
module srbt_fifo #(
    parameter int unsigned WIDTH = 6,
    parameter int unsigned DEPTH = 4
) (
    // clock and reset
    input  wire logic             i_clock,
    input  wire logic             i_reset,
    // fill side
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    // drain side
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int unsigned PW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0]               wr_ptr;
        logic [PW-1:0]               rd_ptr;
        logic [CW-1:0]               count;
    } srbt_fifo_state_s;

    srbt_fifo_state_s s_q;
    srbt_fifo_state_s s_d;
    logic             push;
    logic             pop;

    // wraps explicitly so DEPTH need not be a power of two
    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] ptr);
        next_ptr = (ptr == PW'(DEPTH - 1)) ? '0 : ptr + PW'(1);
    endfunction : next_ptr

    assign o_in_ready  = (s_q.count != CW'(DEPTH));
    assign o_out_valid = (s_q.count != '0);
    assign o_out_data  = s_q.mem[s_q.rd_ptr];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_comb
    begin
        s_d = s_q;
        if (push)
        begin
            s_d.mem[s_q.wr_ptr] = i_in_data;
            s_d.wr_ptr          = next_ptr(s_q.wr_ptr);
        end
        if (pop)
        begin
            s_d.rd_ptr = next_ptr(s_q.rd_ptr);
        end
        if (push && !pop)
        begin
            s_d.count = s_q.count + CW'(1);
        end
        else if (pop && !push)
        begin
            s_d.count = s_q.count - CW'(1);
        end
        if (i_reset)
        begin
            s_d = '0;
        end
    end

    always_ff @(posedge i_clock)
    begin
        s_q <= s_d;
    end
endmodule : srbt_fifo

// >>> src/srbt_transceiver.sv
// Purpose: 3-bit registered bus transceiver with scan, behind AXI4-Lite
// Assumes: bus line inputs already synchronous; bench resolves the wire
// Notes:   control bits live in a register, so "at once" means the edge of the write
//
// Contract
// - three transmit registers drive bus lines, three receive registers drive outputs
// - both sides recirculate their value when no load is selected
// - load select high loads new data on the edge, low holds
// - every register, enable flip-flop too, updates on the rising clock edge
// - outside scan the enable flip-flop captures the clocked bus-drive enable
// - asynchronous drive-off turns bus drivers off without waiting for the enable
// - low preset forces the enable flip-flop to enabled, overriding everything; drive-off still turns the drivers off
// - re-enable either by reloading the enable or by preset low
// - scan high makes all data registers one shift chain, low normal
// - each scan edge shifts once, serial in to receive output msb
// - a low bus bit releases the line, a high bit drives it
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
module srbt_transceiver #(
    parameter int unsigned FIFO_DEPTH = srbt_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic                        i_clock,
    input  wire logic                        i_reset,
    // axi4-lite write address
    input  wire logic [srbt_pkg::ADDR_W-1:0] i_awaddr,
    input  wire logic                        i_awvalid,
    output logic                             o_awready,
    // axi4-lite write data
    input  wire logic [srbt_pkg::DATA_W-1:0] i_wdata,
    input  wire logic [srbt_pkg::STRB_W-1:0] i_wstrb,
    input  wire logic                        i_wvalid,
    output logic                             o_wready,
    // axi4-lite write response
    output logic [1:0]                       o_bresp,
    output logic                             o_bvalid,
    input  wire logic                        i_bready,
    // axi4-lite read address
    input  wire logic [srbt_pkg::ADDR_W-1:0] i_araddr,
    input  wire logic                        i_arvalid,
    output logic                             o_arready,
    // axi4-lite read data
    output logic [srbt_pkg::DATA_W-1:0]      o_rdata,
    output logic [1:0]                       o_rresp,
    output logic                             o_rvalid,
    input  wire logic                        i_rready,
    // cutoff bus lines
    input  wire logic [srbt_pkg::BITS-1:0]   i_bus_line,
    output logic [srbt_pkg::BITS-1:0]        o_bus_line,
    output logic [srbt_pkg::BITS-1:0]        o_bus_line_oe_n,
    // receive outputs, msb doubles as serial out
    output logic [srbt_pkg::BITS-1:0]        o_receive_out
);
    localparam int unsigned B = srbt_pkg::BITS;

    typedef struct packed {
        logic [srbt_pkg::CTRL_W-1:0] ctrl;
        logic [B-1:0]                tx;
        logic [B-1:0]                rx;
        logic                        en_ff;
        logic [B-1:0]                bus_out;
        logic [B-1:0]                bus_oe_n;
        logic                        aw_have;
        logic [srbt_pkg::ADDR_W-1:0] awaddr;
        logic                        w_have;
        logic [srbt_pkg::DATA_W-1:0] wdata;
        logic [srbt_pkg::STRB_W-1:0] wstrb;
        logic                        awready;
        logic                        wready;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        arready;
        logic                        rvalid;
        logic [srbt_pkg::DATA_W-1:0] rdata;
        logic [1:0]                  rresp;
    } srbt_state_s;

    srbt_state_s                   s_q;
    srbt_state_s                   s_d;
    logic                          fifo_wr_valid;
    logic                          fifo_wr_ready;
    logic [srbt_pkg::FIFO_W-1:0]   fifo_wr_data;
    logic                          fifo_rd_valid;
    logic                          fifo_rd_ready;
    logic [srbt_pkg::FIFO_W-1:0]   fifo_rd_data;
    logic                          wr_both;

    assign wr_both       = s_q.aw_have && s_q.w_have && !s_q.bvalid;
    // a full fifo holds the write response back until the core drains a word
    assign fifo_wr_valid = wr_both && (s_q.awaddr == srbt_pkg::OFF_TXDATA) && s_q.wstrb[0];
    assign fifo_wr_data  = {s_q.wdata[srbt_pkg::TX_B_LSB +: B],
                            s_q.wdata[srbt_pkg::TX_A_LSB +: B]};
    assign fifo_rd_ready = s_q.ctrl[srbt_pkg::CTRL_TX_LOAD] && !s_q.ctrl[srbt_pkg::CTRL_SCAN];

    srbt_fifo #(
        .WIDTH (srbt_pkg::FIFO_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_clock     (i_clock),
        .i_reset     (i_reset),
        .i_in_valid  (fifo_wr_valid),
        .o_in_ready  (fifo_wr_ready),
        .i_in_data   (fifo_wr_data),
        .o_out_valid (fifo_rd_valid),
        .i_out_ready (fifo_rd_ready),
        .o_out_data  (fifo_rd_data)
    );

    // fifo level flags; the data port and the status word both show them
    function automatic logic [srbt_pkg::DATA_W-1:0] fifo_word(
        input logic empty,
        input logic full
    );
        logic [srbt_pkg::DATA_W-1:0] w;
        w                          = '0;
        w[srbt_pkg::ST_FIFO_EMPTY] = empty;
        w[srbt_pkg::ST_FIFO_FULL]  = full;
        return w;
    endfunction : fifo_word

    // snapshot of the core as it stood before the edge that takes the address
    function automatic logic [srbt_pkg::DATA_W-1:0] status_word(
        input logic [B-1:0] tx,
        input logic [B-1:0] rx,
        input logic         en_ff,
        input logic [B-1:0] oe_n,
        input logic         empty,
        input logic         full
    );
        logic [srbt_pkg::DATA_W-1:0] w;
        w                           = fifo_word(empty, full);
        w[srbt_pkg::ST_TX_LSB +: B] = tx;
        w[srbt_pkg::ST_RX_LSB +: B] = rx;
        w[srbt_pkg::ST_EN_FF]       = en_ff;
        // one driving line is enough; bits that are released do not count
        w[srbt_pkg::ST_DRIVE]       = (oe_n != '1);
        return w;
    endfunction : status_word

    // drive-off wins over both the enable flip-flop and the preset
    function automatic logic drive_on(
        input logic en_ff,
        input logic preset_n,
        input logic drive_off
    );
        return (en_ff || !preset_n) && !drive_off;
    endfunction : drive_on

    // preset is an overriding set, so the clocked enable is ignored while it is low
    function automatic logic next_en_ff(
        input logic preset_n,
        input logic sync_en
    );
        logic en;
        if (!preset_n)
        begin
            en = 1'b1;
        end
        else
        begin
            en = sync_en;
        end
        return en;
    endfunction : next_en_ff

    always_comb
    begin
        logic drive;
        drive = 1'b0;
        s_d   = s_q;

        // write channels are taken independently, in either order
        if (s_q.awready && i_awvalid)
        begin
            s_d.aw_have = 1'b1;
            s_d.awaddr  = i_awaddr;
        end
        if (s_q.wready && i_wvalid)
        begin
            s_d.w_have = 1'b1;
            s_d.wdata  = i_wdata;
            s_d.wstrb  = i_wstrb;
        end
        if (wr_both && (!fifo_wr_valid || fifo_wr_ready))
        begin
            s_d.aw_have = 1'b0;
            s_d.w_have  = 1'b0;
            s_d.bvalid  = 1'b1;
            s_d.bresp   = srbt_pkg::RESP_OKAY;
            if (s_q.awaddr == srbt_pkg::OFF_CTRL)
            begin
                if (s_q.wstrb[0])
                begin
                    s_d.ctrl = s_q.wdata[srbt_pkg::CTRL_W-1:0];
                end
            end
            else if (s_q.awaddr == srbt_pkg::OFF_TXDATA)
            begin
                s_d.bresp = srbt_pkg::RESP_OKAY;
            end
            else if (s_q.awaddr == srbt_pkg::OFF_STATUS)
            begin
                s_d.bresp = srbt_pkg::RESP_OKAY;
            end
            else
            begin
                s_d.bresp = srbt_pkg::RESP_SLVERR;
            end
        end
        if (s_q.bvalid && i_bready)
        begin
            s_d.bvalid = 1'b0;
        end
        s_d.awready = !s_d.aw_have && !s_d.bvalid;
        s_d.wready  = !s_d.w_have && !s_d.bvalid;

        // read channel
        if (s_q.arready && i_arvalid)
        begin
            s_d.arready = 1'b0;
            s_d.rvalid  = 1'b1;
            s_d.rdata   = '0;
            s_d.rresp   = srbt_pkg::RESP_OKAY;
            if (i_araddr == srbt_pkg::OFF_CTRL)
            begin
                s_d.rdata[srbt_pkg::CTRL_W-1:0] = s_q.ctrl;
            end
            else if (i_araddr == srbt_pkg::OFF_TXDATA)
            begin
                s_d.rdata = fifo_word(!fifo_rd_valid, !fifo_wr_ready);
            end
            else if (i_araddr == srbt_pkg::OFF_STATUS)
            begin
                s_d.rdata = status_word(s_q.tx, s_q.rx, s_q.en_ff, s_q.bus_oe_n,
                                        !fifo_rd_valid, !fifo_wr_ready);
            end
            else
            begin
                s_d.rresp = srbt_pkg::RESP_SLVERR;
            end
        end
        if (s_q.rvalid && i_rready)
        begin
            s_d.rvalid  = 1'b0;
            s_d.arready = 1'b1;
        end

        // data registers; the defaults above recirculate them
        if (s_q.ctrl[srbt_pkg::CTRL_SCAN])
        begin
            s_d.tx = {s_q.tx[B-2:0], s_q.ctrl[srbt_pkg::CTRL_SERIAL_IN]};
            s_d.rx = {s_q.rx[B-2:0], s_q.tx[B-1]};
        end
        else
        begin
            // load with an empty fifo holds, since no new data exists yet
            if (s_q.ctrl[srbt_pkg::CTRL_TX_LOAD] && fifo_rd_valid)
            begin
                s_d.tx = fifo_rd_data[B-1:0] | fifo_rd_data[2*B-1:B];
            end
            if (s_q.ctrl[srbt_pkg::CTRL_RX_LOAD])
            begin
                s_d.rx = i_bus_line;
            end
        end

        // enable flip-flop keeps loading in scan too
        s_d.en_ff = next_en_ff(s_q.ctrl[srbt_pkg::CTRL_PRESET_N],
                               s_q.ctrl[srbt_pkg::CTRL_SYNC_EN]);
        // preset and drive-off act on their new values, not through the enable edge
        drive = drive_on(s_d.en_ff, s_d.ctrl[srbt_pkg::CTRL_PRESET_N],
                         s_d.ctrl[srbt_pkg::CTRL_ASYNC_OFF]);
        s_d.bus_out  = s_d.tx;
        s_d.bus_oe_n = ~(s_d.tx & {B{drive}});

        if (i_reset)
        begin
            s_d          = '0;
            s_d.ctrl     = srbt_pkg::CTRL_RESET;
            s_d.awready  = 1'b1;
            s_d.wready   = 1'b1;
            s_d.arready  = 1'b1;
            s_d.bus_oe_n = '1;
        end
    end

    always_ff @(posedge i_clock)
    begin
        s_q <= s_d;
    end

    assign o_awready       = s_q.awready;
    assign o_wready        = s_q.wready;
    assign o_bresp         = s_q.bresp;
    assign o_bvalid        = s_q.bvalid;
    assign o_arready       = s_q.arready;
    assign o_rdata         = s_q.rdata;
    assign o_rresp         = s_q.rresp;
    assign o_rvalid        = s_q.rvalid;
    assign o_bus_line      = s_q.bus_out;
    assign o_bus_line_oe_n = s_q.bus_oe_n;
    assign o_receive_out   = s_q.rx;
endmodule : srbt_transceiver

// >>> verification/srbt_transceiver_chk.sv
// Purpose: port-level checks for srbt_transceiver
// Assumes: CTRL is mirrored here from the AXI write handshakes
// Notes:   ctrl_c is the CTRL value that the coming edge will use
module srbt_transceiver_chk #(
    parameter int unsigned FIFO_DEPTH = srbt_pkg::FIFO_DEPTH
) (
    // clock and reset
    input wire logic                        i_clock,
    input wire logic                        i_reset,
    // axi4-lite
    input wire logic [srbt_pkg::ADDR_W-1:0] i_awaddr,
    input wire logic                        i_awvalid,
    input wire logic                        o_awready,
    input wire logic [srbt_pkg::DATA_W-1:0] i_wdata,
    input wire logic [srbt_pkg::STRB_W-1:0] i_wstrb,
    input wire logic                        i_wvalid,
    input wire logic                        o_wready,
    input wire logic                        o_bvalid,
    input wire logic [srbt_pkg::ADDR_W-1:0] i_araddr,
    input wire logic                        i_arvalid,
    input wire logic                        o_arready,
    input wire logic [srbt_pkg::DATA_W-1:0] o_rdata,
    // bus and receive side
    input wire logic [srbt_pkg::BITS-1:0]   i_bus_line,
    input wire logic [srbt_pkg::BITS-1:0]   o_bus_line,
    input wire logic [srbt_pkg::BITS-1:0]   o_bus_line_oe_n,
    input wire logic [srbt_pkg::BITS-1:0]   o_receive_out
);
    typedef struct packed {
        logic [3:0] adr;
        logic [6:0] dat;
        logic       stb;
        logic       bv;
        logic [6:0] ctl;
    } srbt_chk_s;
    srbt_chk_s  st_q;
    srbt_chk_s  st_d;
    logic [6:0] ctrl_c;
    logic       sin, pre_n, off, en_s, scan, rxl, txl;

    // a write lands in CTRL at the edge that raises bvalid
    assign ctrl_c = (o_bvalid && !st_q.bv && st_q.adr == srbt_pkg::OFF_CTRL && st_q.stb)
                  ? st_q.dat : st_q.ctl;
    assign {sin, pre_n, off, en_s, scan, rxl, txl} = ctrl_c;

    always_comb
    begin
        st_d = st_q;
        if (i_awvalid && o_awready) st_d.adr = i_awaddr;
        if (i_wvalid && o_wready) st_d.dat = i_wdata[6:0];
        if (i_wvalid && o_wready) st_d.stb = i_wstrb[0];
        st_d.bv = o_bvalid;
        st_d.ctl = i_reset ? srbt_pkg::CTRL_RESET : ctrl_c;
    end

    always_ff @(posedge i_clock)
    begin
        st_q <= st_d;
    end

    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);

    sequence s_drive_steady;
        pre_n && !off;
    endsequence
    sequence s_read_status;
        i_arvalid && o_arready && i_araddr == srbt_pkg::OFF_STATUS;
    endsequence

    AST_SCAN_TX: assert property (scan |=> o_bus_line == {$past(o_bus_line[1:0]), $past(sin)})
        else $error("transmit chain did not shift from serial input");
    AST_SCAN_RX: assert property (scan |=> o_receive_out == {$past(o_receive_out[1:0]), $past(o_bus_line[2])})
        else $error("receive chain did not shift from transmit msb");
    AST_TX_HOLD: assert property (!scan && !txl |=> $stable(o_bus_line))
        else $error("transmit register changed while holding");
    AST_RX_LOAD: assert property (!scan && rxl |=> o_receive_out == $past(i_bus_line))
        else $error("receive register did not load bus level");
    AST_RX_HOLD: assert property (!scan && !rxl |=> $stable(o_receive_out))
        else $error("receive register changed while holding");
    AST_OFF: assert property (off |-> &o_bus_line_oe_n)
        else $error("bus driven while drive-off is set");
    AST_PRESET: assert property (!pre_n && !off |-> o_bus_line_oe_n == ~o_bus_line)
        else $error("preset low did not enable drivers");
    AST_SYNC: assert property (s_drive_steady ##1 s_drive_steady
        |-> o_bus_line_oe_n == ~(o_bus_line & {3{$past(en_s)}}))
        else $error("drivers do not follow clocked enable");
    AST_STATUS: assert property (s_read_status
        |=> o_rdata[6:4] == $past(o_receive_out) && o_rdata[2:0] == $past(o_bus_line))
        else $error("status does not show register contents");
endmodule : srbt_transceiver_chk

bind srbt_transceiver srbt_transceiver_chk #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.*);

// >>> verification/srbt_bus_peer.sv
// Purpose: another registered transceiver sharing the bus lines
// Assumes: bus is wired-OR, a released line reads low
// Notes:   drives the bits the bench asks for, one edge later
module srbt_bus_peer (
    // clock
    input  wire logic       i_clock,
    // requested drive, high bits drive the line
    input  wire logic [2:0] i_value,
    output logic      [2:0] o_drive
);
    timeunit 1ns;
    timeprecision 1ns;

    always_ff @(posedge i_clock)
    begin
        o_drive <= i_value;
    end
endmodule : srbt_bus_peer

// >>> verification/test_scannable_registered_bus_transceiver.sv
// Purpose: self-checking bench for srbt_transceiver
// Assumes: reads are checked in order by the negedge monitor
// Notes:   fixed waits only where one edge per step is promised
module test_scannable_registered_bus_transceiver;
    timeunit 1ns;
    timeprecision 1ns;
    logic        i_clock, i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [3:0]  i_awaddr, i_araddr, i_wstrb;
    logic [31:0] i_wdata, o_rdata;
    logic [1:0]  o_bresp, o_rresp;
    logic [2:0]  i_bus_line, o_bus_line, o_bus_line_oe_n, o_receive_out;
    logic [2:0]  peer_val, peer_drv, last_tx;
    logic [33:0] exp_r[$];
    logic [1:0]  exp_b[$];
    logic [2:0]  exp_t[$];
    int          errors, cmp_count;

    srbt_transceiver DUT (.*);
    srbt_bus_peer u_peer (.i_clock(i_clock), .i_value(peer_val), .o_drive(peer_drv));
    // wired-OR: a released line reads low
    assign i_bus_line = (o_bus_line & ~o_bus_line_oe_n) | peer_drv;

    initial
    begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    function automatic logic [33:0] okv(input logic [31:0] v);
        return {srbt_pkg::RESP_OKAY, v};
    endfunction : okv

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] rsp);
        logic ha, hw, hb;
        exp_b.push_back(rsp);
        @(posedge i_clock);
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do
        begin
            @(negedge i_clock);
            ha = o_awready && i_awvalid;
            hw = o_wready && i_wvalid;
            @(posedge i_clock);
            if (ha) i_awvalid <= 1'b0;
            if (hw) i_wvalid <= 1'b0;
        end
        while ((i_awvalid && !ha) || (i_wvalid && !hw));
        do
        begin
            @(negedge i_clock);
            hb = o_bvalid;
            @(posedge i_clock);
        end
        while (!hb);
        i_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [33:0] e);
        logic h;
        exp_r.push_back(e);
        @(posedge i_clock);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do
        begin
            @(negedge i_clock);
            h = o_arready;
            @(posedge i_clock);
        end
        while (!h);
        i_arvalid <= 1'b0;
        do
        begin
            @(negedge i_clock);
            h = o_rvalid;
            @(posedge i_clock);
        end
        while (!h);
        i_rready <= 1'b0;
    endtask : rd

    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : final_report

    // each result is matched with the oldest note of its kind
    always @(negedge i_clock)
    begin
        if (o_rvalid && i_rready && exp_r.size() > 0)
            check("read", {o_rresp, o_rdata}, exp_r.pop_front());
        if (o_bvalid && i_bready && exp_b.size() > 0)
            check("bresp", {32'h0, o_bresp}, {32'h0, exp_b.pop_front()});
        if (o_bus_line !== last_tx && exp_t.size() > 0)
            check("tx", {31'h0, o_bus_line}, {31'h0, exp_t.pop_front()});
        last_tx = o_bus_line;
    end

    initial
    begin
        repeat (5000) @(posedge i_clock);
        errors++;
        final_report();
    end

    initial
    begin
        logic [31:0] r;
        logic [2:0]  v;
        static logic [6:0]  cv[6] = '{7'h28, 7'h38, 7'h18, 7'h08, 7'h20, 7'h00};
        static logic [11:0] sv[6] = '{12'h707, 12'h507, 12'h507, 12'h707, 12'h407, 12'h707};
        {i_reset, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h20;
        {i_awaddr, i_araddr, i_wdata, peer_val} = '0;
        i_wstrb = 4'hf;
        r = $urandom(56696);
        repeat (3) @(posedge i_clock);
        i_reset <= 1'b0;
        rd(srbt_pkg::OFF_CTRL, okv(32'h20));
        rd(srbt_pkg::OFF_STATUS, okv(32'h400));
        rd(4'hc, {srbt_pkg::RESP_SLVERR, 32'h0});
        wr(4'hc, 32'h0, srbt_pkg::RESP_SLVERR);
        wr(srbt_pkg::OFF_STATUS, 32'hffff, srbt_pkg::RESP_OKAY);
        $display("test registers done");
        // odd values make every pop visible as a change on the bus lines
        for (int i = 0; i < 4; i++)
        begin
            r = $urandom();
            v = 3'(2 * i + 1);
            exp_t.push_back(v);
            wr(srbt_pkg::OFF_TXDATA, {25'h0, v & ~r[2:0], 1'b0, v & r[2:0]}, 2'h0);
        end
        rd(srbt_pkg::OFF_STATUS, okv(32'h800));
        rd(srbt_pkg::OFF_TXDATA, okv(32'h800));
        wr(srbt_pkg::OFF_CTRL, 32'h21, srbt_pkg::RESP_OKAY);
        repeat (4) @(posedge i_clock);
        rd(srbt_pkg::OFF_STATUS, okv(32'h407));
        check("txq", 34'(exp_t.size()), 34'h0);
        $display("test transmit fifo done");
        for (int i = 0; i < 6; i++)
        begin
            wr(srbt_pkg::OFF_CTRL, {25'h0, cv[i]}, srbt_pkg::RESP_OKAY);
            rd(srbt_pkg::OFF_STATUS, okv({20'h0, sv[i]}));
            @(negedge i_clock);
            check("oe_n", 34'(o_bus_line_oe_n), sv[i][9] ? 34'h0 : 34'h7);
        end
        $display("test bus enables done");
        wr(srbt_pkg::OFF_CTRL, 32'h22, srbt_pkg::RESP_OKAY);
        for (int i = 0; i < 4; i++)
        begin
            v = 3'($urandom());
            peer_val <= v;
            repeat (3) @(posedge i_clock);
            rd(srbt_pkg::OFF_STATUS, okv({20'h0, 12'h407 | {5'h0, v, 4'h0}}));
        end
        wr(srbt_pkg::OFF_CTRL, 32'h2a, srbt_pkg::RESP_OKAY);
        rd(srbt_pkg::OFF_STATUS, okv(32'h777));
        $display("test receive done");
        for (int s = 0; s < 2; s++)
        begin
            wr(srbt_pkg::OFF_CTRL, 32'h24 | 32'(s << 6), srbt_pkg::RESP_OKAY);
            repeat (2) @(posedge i_clock);
            wr(srbt_pkg::OFF_CTRL, 32'h20, srbt_pkg::RESP_OKAY);
            rd(srbt_pkg::OFF_STATUS, okv(s ? 32'h477 : 32'h400));
            @(negedge i_clock);
            check("serial", 34'(o_receive_out), s ? 34'h7 : 34'h0);
        end
        $display("test scan done");
        final_report();
    end
endmodule : test_scannable_registered_bus_transceiver
